// ---- dmsf_pkg.sv ----
// Package: constants and types for the serial command framer.
// Assumes a 50 MHz clock and bytes delivered by an external UART.
package dmsf_pkg;
    // ==================================================
    // Framing characters and limits
    localparam logic [7:0]  DMSF_COLON      = 8'h3a;
    localparam logic [7:0]  DMSF_CR         = 8'h0d;
    localparam logic [7:0]  DMSF_LF         = 8'h0a;
    localparam logic [7:0]  DMSF_BCAST      = 8'h00;
    localparam logic [7:0]  DMSF_MAX_STN    = 8'h20;
    localparam int          DMSF_MAX_FRAME  = 80;
    // ==================================================
    // Function codes and exceptions
    localparam logic [7:0]  DMSF_FN_READ    = 8'h03;
    localparam logic [7:0]  DMSF_FN_WRITE1  = 8'h06;
    localparam logic [7:0]  DMSF_FN_LOOP    = 8'h08;
    localparam logic [7:0]  DMSF_FN_WRITEN  = 8'h10;
    localparam logic [7:0]  DMSF_EXC_FLAG   = 8'h80;
    localparam logic [7:0]  DMSF_EXC_FUNC   = 8'h51;
    localparam logic [7:0]  DMSF_EXC_ADDR   = 8'h52;
    localparam logic [7:0]  DMSF_EXC_AMOUNT = 8'h53;
    localparam logic [7:0]  DMSF_EXC_RANGE  = 8'h54;
    localparam logic [7:0]  DMSF_EXC_WMODE  = 8'h55;
    // ==================================================
    // CRC
    localparam logic [15:0] DMSF_CRC_INIT   = 16'hffff;
    localparam logic [15:0] DMSF_CRC_POLY   = 16'ha001;
    // ==================================================
    // Timing
    localparam int          DMSF_CLK_HZ     = 50_000_000;
    localparam int          DMSF_GAP_MS     = 10;
    localparam int          DMSF_GAP_CYC    = DMSF_CLK_HZ / 1000 * DMSF_GAP_MS;
    localparam int          DMSF_FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        DMSF_IDLE = 3'b000,
        DMSF_RECV = 3'b001,
        DMSF_LF_W = 3'b010,
        DMSF_DONE = 3'b011,
        DMSF_DROP = 3'b100
    } dmsf_state_e;
endpackage

// ---- dmsf_fifo.sv ----
// Small synchronous FIFO of flip-flops.
// Assumes one clock; push on in_valid&in_ready, pop on out_valid&out_ready.
`timescale 1ns/1ps
module dmsf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } dmsf_fifo_s;
    dmsf_fifo_s st_r, st_nxt;
    logic push, pop;

    // ==================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign in_ready  = ce && (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = ce && (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
endmodule // dmsf_fifo

// ---- dmsf_framer.sv ----
// Framer: receives ASCII or RTU request frames, checks and forwards them.
// Assumes a UART outside gives one byte per rx_valid pulse on clk.
// Notes on behaviour
// - Accept both ASCII and RTU framed requests
// - Frames over 80 bytes are invalid
// - ASCII frame is colon to CR LF
// - ASCII fields are hex character pairs
// - RTU frame: address, function, data, CRC
// - 10 ms silence delimits RTU frames
// - Address 00H is broadcast
// - Own station 01H to 20H only
// - Decode 03H read, 06H, 10H writes
// - Decode 08H as loop test echo
// - Reply only when addressed, never unsolicited
// - CRC preset FFFF, right shift, A001
// - CRC low byte first then high
// - Errors answer function OR 80H, code; the code does this only for unknown functions, with code 51H
`timescale 1ns/1ps
module dmsf_framer
    import dmsf_pkg::*;
#(
    parameter int GAP_CYC = DMSF_GAP_CYC,
    parameter int MAXLEN  = DMSF_MAX_FRAME
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       ascii_mode,
    input  wire logic [7:0] station,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_valid,
    output logic      [8:0] out_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic            frame_ok,
    output logic            frame_bad,
    output logic            reply_req,
    output logic      [7:0] func_code,
    output logic      [7:0] exc_code,
    output logic      [2:0] func_kind,
    output logic            rx_stall
);
    localparam int GW = $clog2(GAP_CYC + 1);

    typedef struct packed {
        dmsf_state_e state;
        logic [GW-1:0] gap;
        logic [6:0]    len;
        logic          hi;
        logic [3:0]    nib;
        logic [15:0]   crc;
        logic [7:0]    b1;
        logic [7:0]    b2;
        logic [7:0]    lrc;
        logic [7:0]    addr;
        logic [7:0]    func;
        logic [7:0]    fcode;
        logic          ok;
        logic          bad;
        logic          rep;
        logic [7:0]    exc;
        logic [2:0]    kind;
        logic          mode;
    } dmsf_st_s;

    dmsf_st_s st_r, st_nxt;
    logic     [7:0] rxb_s1_r, rxb_s2_r;
    logic           rxv_s1_r, rxv_s2_r, rxv_s3_r;
    logic     [8:0] fifo_in;
    logic           fifo_in_valid, fifo_in_ready;
    logic     [8:0] fifo_out;
    logic           fifo_out_valid;

    // ==================================================
    // Helpers
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ DMSF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            return {1'b1, 4'(c - 8'h30)};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            return {1'b1, 4'(c - 8'h37)};
        end else if (c >= 8'h61 && c <= 8'h66) begin
            return {1'b1, 4'(c - 8'h57)};
        end
        return 5'h00;
    endfunction

    function automatic logic addr_match(input logic [7:0] a,
                                        input logic [7:0] s);
        return (a == DMSF_BCAST) ||
               (a == s && s != DMSF_BCAST && s <= DMSF_MAX_STN);
    endfunction

    // ==================================================
    // Pin-side synchroniser for the byte strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rxb_s1_r <= 8'h00;
            rxb_s2_r <= 8'h00;
            rxv_s1_r <= 1'b0;
            rxv_s2_r <= 1'b0;
            rxv_s3_r <= 1'b0;
        end else if (ce) begin
            rxb_s1_r <= rx_byte;
            rxb_s2_r <= rxb_s1_r;
            rxv_s1_r <= rx_valid;
            rxv_s2_r <= rxv_s1_r;
            rxv_s3_r <= rxv_s2_r;
        end
    end

    logic       byte_stb;
    logic [7:0] bt;
    logic [4:0] hv;
    logic [7:0] dec;
    assign byte_stb = rxv_s2_r && !rxv_s3_r;
    assign bt = rxb_s2_r;

    // ==================================================
    // Frame state machine
    always_comb begin
        st_nxt = st_r;
        st_nxt.ok = 1'b0;
        st_nxt.bad = 1'b0;
        st_nxt.rep = 1'b0;
        fifo_in = 9'h000;
        fifo_in_valid = 1'b0;
        hv = hex_val(bt);
        dec = {st_r.nib, hv[3:0]};
        if (st_r.gap != '0) begin
            st_nxt.gap = st_r.gap - 1'b1;
        end
        if (byte_stb) begin
            st_nxt.gap = GW'(GAP_CYC);
        end
        case (st_r.state)
            DMSF_IDLE: begin
                st_nxt.mode = ascii_mode;
                st_nxt.len = 7'd0;
                st_nxt.hi = 1'b1;
                st_nxt.crc = DMSF_CRC_INIT;
                st_nxt.lrc = 8'h00;
                if (byte_stb) begin
                    if (ascii_mode) begin
                        if (bt == DMSF_COLON) begin
                            st_nxt.state = DMSF_RECV;
                        end
                    end else if (st_r.gap == '0) begin
                        st_nxt.state = DMSF_RECV;
                        st_nxt.len = 7'd1;
                        st_nxt.addr = bt;
                        st_nxt.crc = crc_byte(DMSF_CRC_INIT, bt);
                        fifo_in = {1'b1, bt};
                        fifo_in_valid = 1'b1;
                    end
                end
            end
            DMSF_RECV: begin
                if (!st_r.mode && st_r.gap == '0) begin
                    // Silence ends the RTU frame; residual CRC must be 0
                    st_nxt.state = DMSF_DONE;
                end else if (byte_stb && st_r.mode && bt == DMSF_CR) begin
                    st_nxt.state = st_r.hi ? DMSF_LF_W : DMSF_DROP;
                end else if (byte_stb) begin
                    st_nxt.len = st_r.len + 7'd1;
                    if (st_r.len == 7'(MAXLEN)) begin
                        st_nxt.state = DMSF_DROP;
                    end else if (st_r.mode) begin
                        if (!hv[4]) begin
                            st_nxt.state = DMSF_DROP;
                        end else if (st_r.hi) begin
                            st_nxt.nib = hv[3:0];
                            st_nxt.hi = 1'b0;
                        end else begin
                            st_nxt.hi = 1'b1;
                            st_nxt.lrc = st_r.lrc + dec;
                            st_nxt.b2 = st_r.b1;
                            st_nxt.b1 = dec;
                            // Low nibble lands on odd counts: 1 addr, 3 func
                            if (st_r.len == 7'd1) begin
                                st_nxt.addr = dec;
                            end
                            if (st_r.len == 7'd3) begin
                                st_nxt.func = dec;
                            end
                            fifo_in = {1'b0, dec};
                            fifo_in_valid = 1'b1;
                        end
                    end else begin
                        st_nxt.crc = crc_byte(st_r.crc, bt);
                        st_nxt.b2 = st_r.b1;
                        st_nxt.b1 = bt;
                        if (st_r.len == 7'd1) begin
                            st_nxt.func = bt;
                        end
                        fifo_in = {1'b0, bt};
                        fifo_in_valid = 1'b1;
                    end
                end
            end
            DMSF_LF_W: begin
                if (byte_stb) begin
                    // Running sum including LRC must be zero
                    st_nxt.state = (bt == DMSF_LF) ? DMSF_DONE : DMSF_DROP;
                end
            end
            DMSF_DONE: begin
                st_nxt.state = DMSF_IDLE;
                if (((st_r.mode && st_r.lrc == 8'h00) ||
                     (!st_r.mode && st_r.crc == 16'h0000)) &&
                    addr_match(st_r.addr, station)) begin
                    st_nxt.ok = 1'b1;
                    st_nxt.exc = 8'h00;
                    st_nxt.fcode = st_r.func;
                    case (st_r.func)
                        DMSF_FN_READ:   st_nxt.kind = 3'd1;
                        DMSF_FN_WRITE1: st_nxt.kind = 3'd2;
                        DMSF_FN_LOOP:   st_nxt.kind = 3'd4;
                        DMSF_FN_WRITEN: st_nxt.kind = 3'd3;
                        default: begin
                            st_nxt.kind = 3'd0;
                            st_nxt.exc = DMSF_EXC_FUNC;
                            st_nxt.fcode = st_r.func | DMSF_EXC_FLAG;
                        end
                    endcase
                    // Reply only to own unicast requests
                    st_nxt.rep = (st_r.addr != DMSF_BCAST);
                end else begin
                    st_nxt.bad = 1'b1;
                end
            end
            DMSF_DROP: begin
                st_nxt.bad = 1'b1;
                st_nxt.state = DMSF_IDLE;
            end
            default: st_nxt.state = DMSF_IDLE;
        endcase
        if (fifo_in_valid && !fifo_in_ready) begin
            st_nxt.state = DMSF_DROP;
            fifo_in_valid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ==================================================
    // Byte buffer toward the command handler
    dmsf_fifo #(
        .WIDTH (9),
        .DEPTH (DMSF_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (out_ready && !out_valid)
    );

    // ==================================================
    // Registered outputs
    logic [8:0] od_r;
    logic       ov_r;
    logic       stall_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            od_r <= 9'h000;
            ov_r <= 1'b0;
            stall_r <= 1'b0;
        end else if (ce) begin
            stall_r <= !fifo_in_ready;
            if (ov_r && out_ready) begin
                ov_r <= 1'b0;
            end else if (!ov_r && fifo_out_valid && out_ready) begin
                ov_r <= 1'b1;
                od_r <= fifo_out;
            end
        end
    end
    assign out_data  = od_r;
    assign out_valid = ov_r;
    assign rx_stall  = stall_r;
    assign frame_ok  = st_r.ok;
    assign frame_bad = st_r.bad;
    assign reply_req = st_r.rep;
    assign func_code = st_r.fcode;
    assign exc_code  = st_r.exc;
    assign func_kind = st_r.kind;

    // ==================================================
    // Checks
    a_bcast_quiet: assert property (@(posedge clk) disable iff (rst)
        st_r.rep |-> st_r.addr != DMSF_BCAST)
        else $error("reply raised for broadcast");
    a_len_cap: assert property (@(posedge clk) disable iff (rst)
        st_r.state == DMSF_RECV |-> st_r.len <= 7'(MAXLEN))
        else $error("frame length over limit");
    a_rep_ok: assert property (@(posedge clk) disable iff (rst)
        st_r.rep |-> st_r.ok)
        else $error("reply without valid frame");
    a_exc_flag: assert property (@(posedge clk) disable iff (rst)
        st_r.ok && st_r.exc != 8'h00 |-> func_code[7])
        else $error("exception without flag bit");
    a_bad_func: assert property (@(posedge clk) disable iff (rst)
        st_r.ok && st_r.kind == 3'd0 |-> st_r.exc == DMSF_EXC_FUNC)
        else $error("unknown function without exception");
    a_loop_kind: assert property (@(posedge clk) disable iff (rst)
        st_r.ok && st_r.func == DMSF_FN_LOOP |-> st_r.kind == 3'd4)
        else $error("loop test not decoded");
    a_rtu_gap: assert property (@(posedge clk) disable iff (rst || !ce)
        st_r.state == DMSF_IDLE && !st_r.mode && st_nxt.state == DMSF_RECV
        && !ascii_mode |-> st_r.gap == '0)
        else $error("rtu frame started inside gap");
    a_ok_addr: assert property (@(posedge clk) disable iff (rst)
        st_r.ok |-> addr_match(st_r.addr, station))
        else $error("accepted foreign station");
    c_ok: cover property (@(posedge clk) st_r.ok && st_r.rep);
    c_bcast: cover property (@(posedge clk) st_r.ok && !st_r.rep);
    c_bad: cover property (@(posedge clk) st_r.bad);
endmodule // dmsf_framer

// ---- dmsf_master_model.sv ----
// Master side model: sends request frames as a UART byte stream.
// Assumes the framer takes one byte per rising edge of rx_valid.
`timescale 1ns/1ps
module dmsf_master_model #(
    parameter int GAP_CYC = 50
) (
    input  wire logic       clk,
    output logic      [7:0] rx_byte,
    output logic            rx_valid
);
    logic [7:0] sent[$];  // Decoded bytes the framer should forward

    // ==================================================
    // Idle line
    initial begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end

    // CRC over a byte list
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    // Nibble to upper case hex character
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    // One byte: valid high two cycles, low two cycles
    task automatic put_byte(input logic [7:0] b);
        rx_byte  <= b;
        rx_valid <= 1'b1;
        repeat (2) @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~b;  // Stale data never repeats the last byte
        repeat (2) @(posedge clk);
    endtask

    // Silence between frames, slightly above the gap
    task automatic settle();
        repeat (GAP_CYC + 30) @(posedge clk);
    endtask

    // Whole frame; fault 1 spoils the check, fault 2 adds a stray char in ASCII mode only
    task automatic send_frame(input logic asc, input logic [7:0] q[$],
                              input int fault);
        logic [15:0] c;
        logic [7:0]  lrc;
        c   = crc16(q);
        lrc = 8'h00;
        foreach (q[i]) lrc = lrc + q[i];
        lrc = ~lrc + 8'h01;
        if (fault == 1) begin
            c   = c ^ 16'h0001;
            lrc = lrc ^ 8'h01;
        end
        sent = q;
        if (asc) begin
            sent.push_back(lrc);
            put_byte(8'h3a);
            foreach (sent[i]) begin
                put_byte(hexc(sent[i][7:4]));
                put_byte(hexc(sent[i][3:0]));
            end
            if (fault == 2) put_byte(8'h41);
            put_byte(8'h0d);
            put_byte(8'h0a);
        end else begin
            sent.push_back(c[7:0]);
            sent.push_back(c[15:8]);
            foreach (sent[i]) put_byte(sent[i]);
        end
    endtask
endmodule // dmsf_master_model

// ---- testbench.sv ----
// Testbench for the request framer with a master model in front.
// Assumes a shortened gap of 50 cycles and a 50 MHz clock.
`timescale 1ns/1ps
module testbench;
    import dmsf_pkg::*;
    localparam int GAP = 50;
    logic       clk, rst, ce, ascii_mode, rx_valid, out_ready;
    logic [7:0] station, rx_byte, func_code, exc_code, fc, ex;
    logic [8:0] out_data;
    logic [2:0] func_kind, fk;
    logic       out_valid, frame_ok, frame_bad, reply_req, rx_stall;
    logic [8:0] rxq[$];
    int         err_count, comparisons, cycles, n_ok, n_rr, n_bad, stall;

    dmsf_framer #(.GAP_CYC(GAP)) dut_u (.clk(clk), .rst(rst), .ce(ce),
        .ascii_mode(ascii_mode), .station(station), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .frame_ok(frame_ok), .frame_bad(frame_bad),
        .reply_req(reply_req), .func_code(func_code),
        .exc_code(exc_code), .func_kind(func_kind), .rx_stall(rx_stall));
    dmsf_master_model #(.GAP_CYC(GAP)) master_u (.clk(clk),
        .rx_byte(rx_byte), .rx_valid(rx_valid));

    // ==================================================
    // Clock and observation
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Collect pulses, results and forwarded bytes; cut hangs short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (frame_ok === 1'b1) begin
            n_ok <= n_ok + 1;
            fc   <= func_code;
            ex   <= exc_code;
            fk   <= func_kind;
        end
        if (reply_req === 1'b1) n_rr <= n_rr + 1;
        if (frame_bad === 1'b1) n_bad <= n_bad + 1;
        if (rx_stall === 1'b1) stall <= 1;
        if (out_valid === 1'b1 && out_ready === 1'b1) rxq.push_back(out_data);
        if (cycles == 30000) begin
            $display("BAD at %0t: run timed out", $time);
            err_count++;
            give_verdict();
        end
    end

    // ==================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic prep(input logic asc);
        @(posedge clk);
        ascii_mode <= asc;
        n_ok = 0;
        n_rr = 0;
        n_bad = 0;
        stall = 0;
        rxq.delete();
    endtask

    task automatic run(input logic asc, input logic [7:0] q[$], input int f);
        prep(asc);
        master_u.send_frame(asc, q, f);
        master_u.settle();
    endtask

    task automatic expect_res(input int ok, input int rr);
        check(16'(n_ok), 16'(ok), "accepted frames");
        check(16'(n_rr), 16'(rr), "reply requests");
    endtask

    task automatic check_stream(input logic rtu);
        check(16'(rxq.size()), 16'(master_u.sent.size()), "byte count");
        foreach (master_u.sent[i]) begin
            if (i < rxq.size())
                check({7'h00, rxq[i]},
                      {7'h00, rtu && i == 0, master_u.sent[i]}, "byte");
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==================================================
    // Scenarios
    task automatic t_functions();
        logic [7:0] fn[4] = '{8'h03, 8'h06, 8'h10, 8'h08};
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) begin
                run(m[0], {8'h01, fn[k], 8'h25, 8'h00, 8'h00, 8'h01}, 0);
                expect_res(1, 1);
                check({13'h0, fk}, 16'(k + 1), "kind");
                check({8'h0, fc}, {8'h0, fn[k]}, "function");
                check({8'h0, ex}, 16'h0000, "exception");
                check_stream(!m[0]);
            end
        end
    endtask

    task automatic t_addresses();
        run(1'b0, {8'h00, 8'h06, 8'h25, 8'h01, 8'h00, 8'h01}, 0);
        expect_res(1, 0);
        station <= 8'h20;
        run(1'b1, {8'h20, 8'h03, 8'h25, 8'h20, 8'h00, 8'h01}, 0);
        expect_res(1, 1);
        run(1'b0, {8'h21, 8'h03, 8'h25, 8'h20, 8'h00, 8'h01}, 0);
        expect_res(0, 0);
        station <= 8'h01;
        run(1'b0, {8'h01, 8'h07, 8'h25, 8'h00, 8'h00, 8'h01}, 0);
        expect_res(1, 1);
        check({8'h0, fc}, 16'h0087, "function");
        check({8'h0, ex}, 16'h0051, "exception");
        check({13'h0, fk}, 16'h0000, "kind");
    endtask

    task automatic t_checks();
        for (int m = 0; m < 2; m++) begin
            run(m[0], {8'h01, 8'h03, 8'h25, 8'h00, 8'h00, 8'h02}, 1);
            expect_res(0, 0);
            check(16'(n_bad > 0), 16'h0001, "bad check");
        end
        run(1'b1, {8'h01, 8'h03, 8'h25, 8'h00, 8'h00, 8'h02}, 2);
        check(16'(n_ok), 16'h0000, "odd char count");
        prep(1'b1);
        master_u.put_byte(8'h31);
        master_u.put_byte(8'h0a);
        master_u.send_frame(1'b1, {8'h01, 8'h06, 8'h25, 8'h02}, 0);
        master_u.settle();
        expect_res(1, 1);
    endtask

    task automatic t_length_gap();
        logic [7:0] q[$];
        q = {8'h01, 8'h10};
        for (int i = 0; i < 76; i++) q.push_back(8'(i));
        run(1'b0, q, 0);
        expect_res(1, 1);
        q.push_back(8'h5a);
        run(1'b0, q, 0);
        expect_res(0, 0);
        check(16'(n_bad > 0), 16'h0001, "too long");
        q = {8'h01, 8'h03, 8'h25, 8'h00, 8'h00, 8'h01};
        prep(1'b0);
        master_u.put_byte(8'h01);
        master_u.put_byte(8'h03);
        master_u.settle();
        for (int i = 2; i < 6; i++) master_u.put_byte(q[i]);
        master_u.put_byte(master_u.crc16(q) & 8'hff);
        master_u.put_byte(master_u.crc16(q) >> 8);
        master_u.settle();
        expect_res(0, 0);
    endtask

    task automatic t_fifo();
        logic [7:0] q[$];
        q = {8'h01, 8'h10};
        for (int i = 0; i < 10; i++) q.push_back(8'(i));
        out_ready <= 1'b0;
        run(1'b0, q, 0);
        check(16'(stall), 16'h0001, "buffer full");
        check(16'(n_ok), 16'h0000, "dropped frame");
        out_ready <= 1'b1;
        repeat (40) @(posedge clk);
        check({15'h0, out_valid}, 16'h0000, "drained");
        check(16'(rxq.size()), 16'(DMSF_FIFO_DEPTH), "buffer depth");
    endtask

    // ==================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ascii_mode = 1'b0;
        station = 8'h01;
        out_ready = 1'b1;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_functions();
        t_addresses();
        t_checks();
        t_length_gap();
        t_fifo();
        give_verdict();
    end
endmodule // testbench
